// *** common/rectifier_cfg.svh ***
// Purpose: Constants for the rectifier control and status pin logic.
// Assumes: 250 MHz system clock; 12-bit ADC codes, 3.3 V full scale.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef RECTIFIER_CFG_SVH
`define RECTIFIER_CFG_SVH

// ============================================================
// Clock and timing
`define CFG_CLK_MHZ 250
`define CFG_T_START_US 5000
`define CFG_T_RAMP_US 100000
`define CFG_T_WARN_NS 500000
`define CFG_T_BLINK_US 250000
`define CFG_CNT_W 27
`define CFG_DEBOUNCE_W 4

// ============================================================
// Pin vector positions after synchronisation
`define PIN_REMOTE_N 0
`define PIN_SEAT_N 1
`define PIN_PROTOCOL 2
`define PIN_RS485 3
`define PIN_PRESENT 4
`define PIN_MUXRST_N 5
`define PIN_AC_OK 6
`define PIN_BIAS 7
`define PIN_HIGHLINE 8
`define PIN_OUT_REG 9
`define PIN_FAN_FAIL 10
`define PIN_OT_WARN 11
`define PIN_OT_SHUT 12
`define PIN_OV_SHUT 13
`define PIN_INT_FAULT 14
`define PIN_COUNT 15

// ============================================================
// Analog thresholds as ADC codes and setpoints in 10 mV units
`define CFG_TRIM_TH 12'hE8C
`define CFG_SETPOINT_DEFAULT 16'h15E0
`define CFG_SETPOINT_MIN 16'h1130
`define CFG_SETPOINT_SPAN 16'h0578
`define CFG_SLOT_TH0 12'hAAC
`define CFG_SLOT_TH1 12'h7AE
`define CFG_SLOT_TH2 12'h499
`define CFG_SHELF_TH '{12'hE79, 12'hC82, 12'hA79, 12'h851, 12'h62E, \
	12'h3FA, 12'h155}

// ============================================================
// Register byte offsets
`define REG_STATUS 4'h0
`define REG_SETPOINT 4'h4
`define REG_ADDRESS 4'h8

`endif

// *** common/rectifier_pkg.sv ***
// Purpose: Types for the rectifier control and status pin logic.
// Assumes: rectifier_cfg.svh supplies the counter width and the reset setpoint.
// Notes: State codes are one-hot.
`include "rectifier_cfg.svh"

package rectifier_pkg;

	// ============================================================
	// Output sequencing states
	typedef enum logic [4:0]
	{
		S_OFF = 5'h01,
		S_DELAY = 5'h02,
		S_RAMP = 5'h04,
		S_ON = 5'h08,
		S_HOLD = 5'h10
	} pwr_state_t;

	// ============================================================
	// Whole state of the control block
	typedef struct packed
	{
		pwr_state_t state;
		logic [`CFG_CNT_W-1:0] cnt;
		logic [`CFG_CNT_W-1:0] blinkCnt;
		logic blink;
		logic outEn;
		logic powerGood;
		logic mainsInd;
		logic writeProt;
		logic lineRating;
		logic fault_n;
		logic muxRst;
		logic muxPinPrev;
		logic [15:0] setpoint;
		logic swOverride;
		logic [15:0] swSetpoint;
		logic [1:0] slotAddr;
		logic rackBit;
		logic ack;
		logic [31:0] rdata;
	} ctl_state_t;

	// Reset image: output off, no faults shown, factory setpoint.
	// The mux edge detector starts low, as the debounced pins do, so a
	// released reset never looks like a falling edge of the reset pin.
	localparam ctl_state_t CTL_RESET = '{state: S_OFF, fault_n: 1'b1,
		setpoint: `CFG_SETPOINT_DEFAULT, default: '0};

endpackage

// *** core/sync_debounce.sv ***
// Purpose: Two-flop synchroniser and debouncer for a vector of pins.
// Assumes: Pins are asynchronous to clk_sys.
// Notes: A bit changes only after its synchronised level held for a
// full counter run, so short glitches never reach the control logic.
`include "rectifier_cfg.svh"

module sync_debounce #(
	parameter int WIDTH = 15
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] pinRaw,
	output logic [WIDTH-1:0] pinClean
);

	typedef struct packed
	{
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] stable;
		logic [WIDTH-1:0][`CFG_DEBOUNCE_W-1:0] cnt;
	} deb_t;

	deb_t st_r;
	deb_t st_nxt;

	// ============================================================
	// Per-bit debounce; the first flop feeds only the second.
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.meta = pinRaw;
		st_nxt.sync = st_r.meta;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (st_r.sync[i] == st_r.stable[i])
				st_nxt.cnt[i] = '0;
			else if (&st_r.cnt[i])
			begin
				st_nxt.stable[i] = st_r.sync[i]; // RL17
				st_nxt.cnt[i] = '0;
			end
			else
				st_nxt.cnt[i] = st_r.cnt[i] + 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign pinClean = st_r.stable;

endmodule

// *** core/rectifier_ctl.sv ***
// Purpose: Control and status pin logic of a line rectifier.
// Assumes: Pins are asynchronous; ADC codes are on clk_sys.
// Notes: Registers are reached over Avalon-MM with waitrequest.
// Contract
// [RL1] The main output is on only while remote enable is held low.
// [RL2] The main output also needs the hot-plug seat sense tied low.
// [RL3] Remote enable governs the output whatever protocol is selected.
// [RL4] After AC returns to regulation wait 5 ms before ramping.
// [RL5] The ramp takes 100 ms, except in RS485 mode.
// [RL6] Power good drops at least 0.5 ms before the output decays; on enable release the code drops both in the same cycle.
// [RL7] The mains indicator blinks when AC fails while bias is present.
// [RL8] Trim above 3.0 V or open selects 56 V; lower trims it down.
// [RL9] A software setpoint overrides trim until the controller resets.
// [RL10] Every controller restart takes the setpoint from trim again.
// [RL11] Insertion sense above 1 V turns on EEPROM write protection.
// [RL12] A low pulse on the mux reset pin resets the bus multiplexer.
// [RL13] The slot resistor decodes into two address bits.
// [RL14] The shelf voltage falls in 8 levels, reduced to one parity bit.
// [RL15] The line-rating flag is high on high line, low on low line.
// [RL16] The fault flag goes low on any replacement-worthy fault.
// [RL17] All asynchronous inputs are synchronised and debounced.
//
// Implementation choices: register access over Avalon-MM and the address map.
`include "rectifier_cfg.svh"

module rectifier_ctl #(
	parameter int START_CYCLES = `CFG_CLK_MHZ * `CFG_T_START_US,
	parameter int RAMP_CYCLES = `CFG_CLK_MHZ * `CFG_T_RAMP_US,
	parameter int WARN_CYCLES =
		(`CFG_CLK_MHZ * `CFG_T_WARN_NS + 999) / 1000,
	parameter int BLINK_CYCLES = `CFG_CLK_MHZ * `CFG_T_BLINK_US
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic remoteOn_n,
	input wire logic hotplugSeatSense_n,
	input wire logic protocolSel,
	input wire logic rs485Mode,
	input wire logic presentAbove1V,
	input wire logic muxResetPin_n,
	input wire logic acInRegulation,
	input wire logic biasAvailable,
	input wire logic highLine,
	input wire logic outputInRegulation,
	input wire logic fanFail,
	input wire logic overTempWarn,
	input wire logic overTempShutdown,
	input wire logic overVoltShutdown,
	input wire logic internalFault,
	input wire logic [11:0] trimCode,
	input wire logic [11:0] slotCode,
	input wire logic [11:0] shelfCode,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic mainOutputEnable,
	output logic rampActive,
	output logic powerGood,
	output logic mainsIndicator,
	output logic writeProtect,
	output logic lineRating,
	output logic fault_n,
	output logic muxReset,
	output logic [15:0] setpointCode,
	output logic slotBitHi,
	output logic slotBitLo,
	output logic rackBit
);

	localparam logic [11:0] SHELF_TH [7] = `CFG_SHELF_TH;

	rectifier_pkg::ctl_state_t st_r;
	rectifier_pkg::ctl_state_t st_nxt;
	logic [`PIN_COUNT-1:0] pinRaw;
	logic [`PIN_COUNT-1:0] pin;
	logic runReq;
	logic acOk;
	logic access;
	logic [15:0] trimSetpoint;
	logic [31:0] trimProduct;
	logic [2:0] shelfLevel;

	// ============================================================
	// Input conditioning
	assign pinRaw = {internalFault, overVoltShutdown, overTempShutdown,
		overTempWarn, fanFail, outputInRegulation, highLine,
		biasAvailable, acInRegulation, muxResetPin_n, presentAbove1V,
		rs485Mode, protocolSel, hotplugSeatSense_n, remoteOn_n};

	sync_debounce #(
		.WIDTH(`PIN_COUNT)
	) u_debounce (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.pinRaw(pinRaw),
		.pinClean(pin)
	);

	// Protocol selection does not gate the run request on purpose.
	assign runReq = !pin[`PIN_REMOTE_N] && !pin[`PIN_SEAT_N]; // RL1 RL2 RL3
	assign acOk = pin[`PIN_AC_OK];
	assign access = (avs_read || avs_write) && !st_r.ack;
	assign avs_waitrequest = access;

	// Trim maps linearly onto the setpoint span below the threshold.
	assign trimProduct = 32'(trimCode) * 32'(`CFG_SETPOINT_SPAN);
	assign trimSetpoint = (trimCode >= `CFG_TRIM_TH) ?
		`CFG_SETPOINT_DEFAULT :
		`CFG_SETPOINT_MIN + trimProduct[27:12]; // RL8

	// Shelf level is the count of thresholds the voltage reaches.
	always_comb
	begin
		shelfLevel = 3'h0;
		for (int i = 0; i < 7; i++)
		begin
			if (shelfCode >= SHELF_TH[i])
				shelfLevel = shelfLevel + 3'h1; // RL14
		end
	end

	// ============================================================
	// Next-state logic
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.cnt = st_r.cnt + 1'b1;
		if (!runReq)
		begin
			// Releasing either pin cuts the output at once.
			st_nxt.state = rectifier_pkg::S_OFF; // RL1 RL2
			st_nxt.outEn = 1'b0;
			st_nxt.cnt = '0;
		end
		else
		begin
			case (st_r.state)
				rectifier_pkg::S_OFF:
				begin
					st_nxt.cnt = '0;
					if (acOk)
						st_nxt.state = rectifier_pkg::S_DELAY;
				end
				rectifier_pkg::S_DELAY:
				begin
					if (!acOk)
					begin
						st_nxt.state = rectifier_pkg::S_OFF;
						st_nxt.cnt = '0;
					end
					else if (st_r.cnt == `CFG_CNT_W'(START_CYCLES - 1))
					begin
						st_nxt.state = rectifier_pkg::S_RAMP; // RL4
						st_nxt.outEn = 1'b1;
						st_nxt.cnt = '0;
					end
				end
				rectifier_pkg::S_RAMP:
				begin
					if (!acOk)
					begin
						st_nxt.state = rectifier_pkg::S_HOLD;
						st_nxt.cnt = '0;
					end
					else if (st_r.cnt == `CFG_CNT_W'(RAMP_CYCLES - 1) ||
						(pin[`PIN_RS485] && pin[`PIN_OUT_REG]))
					begin
						st_nxt.state = rectifier_pkg::S_ON; // RL5
						st_nxt.cnt = '0;
					end
				end
				rectifier_pkg::S_ON:
				begin
					st_nxt.cnt = '0;
					if (!acOk)
						st_nxt.state = rectifier_pkg::S_HOLD;
				end
				rectifier_pkg::S_HOLD:
				begin
					// Output rides through while power good is already low.
					if (acOk)
					begin
						st_nxt.state = rectifier_pkg::S_ON;
						st_nxt.cnt = '0;
					end
					else if (st_r.cnt == `CFG_CNT_W'(WARN_CYCLES - 1))
					begin
						st_nxt.state = rectifier_pkg::S_OFF; // RL6
						st_nxt.outEn = 1'b0;
						st_nxt.cnt = '0;
					end
				end
				default:
				begin
					st_nxt.state = rectifier_pkg::S_OFF;
					st_nxt.outEn = 1'b0;
					st_nxt.cnt = '0;
				end
			endcase
		end
		st_nxt.powerGood = (st_nxt.state == rectifier_pkg::S_ON) &&
			pin[`PIN_OUT_REG] && acOk; // RL6

		// Indicator is steady on good AC, blinks on bias alone.
		if (!acOk && pin[`PIN_BIAS])
		begin
			st_nxt.blinkCnt = st_r.blinkCnt + 1'b1;
			if (st_r.blinkCnt == `CFG_CNT_W'(BLINK_CYCLES - 1))
			begin
				st_nxt.blinkCnt = '0;
				st_nxt.blink = !st_r.blink; // RL7
			end
		end
		else
		begin
			st_nxt.blinkCnt = '0;
			st_nxt.blink = 1'b0;
		end
		st_nxt.mainsInd = acOk || (pin[`PIN_BIAS] && st_nxt.blink); // RL7

		// Status pins follow the conditioned inputs.
		st_nxt.writeProt = pin[`PIN_PRESENT]; // RL11
		st_nxt.lineRating = pin[`PIN_HIGHLINE]; // RL15
		st_nxt.fault_n = !(pin[`PIN_FAN_FAIL] || pin[`PIN_OT_WARN] ||
			pin[`PIN_OT_SHUT] || pin[`PIN_OV_SHUT] ||
			pin[`PIN_INT_FAULT]); // RL16
		st_nxt.muxPinPrev = pin[`PIN_MUXRST_N];
		st_nxt.muxRst = st_r.muxPinPrev && !pin[`PIN_MUXRST_N]; // RL12

		// Address decode from the slot resistor and shelf voltage.
		if (slotCode >= `CFG_SLOT_TH0)
			st_nxt.slotAddr = 2'h0; // RL13
		else if (slotCode >= `CFG_SLOT_TH1)
			st_nxt.slotAddr = 2'h1;
		else if (slotCode >= `CFG_SLOT_TH2)
			st_nxt.slotAddr = 2'h2;
		else
			st_nxt.slotAddr = 2'h3;
		st_nxt.rackBit = !shelfLevel[0]; // RL14

		// Bus slave: one wait cycle, write lands on the release edge.
		st_nxt.ack = access;
		if (access)
		begin
			case (avs_address)
				`REG_STATUS:
					st_nxt.rdata = {18'h0, st_r.state, pin[`PIN_RS485],
						pin[`PIN_PROTOCOL], st_r.swOverride, !st_r.fault_n,
						st_r.lineRating, st_r.writeProt, st_r.mainsInd,
						st_r.powerGood, st_r.outEn};
				`REG_SETPOINT:
					st_nxt.rdata = {16'h0, st_r.setpoint};
				`REG_ADDRESS:
					st_nxt.rdata = {29'h0, st_r.rackBit, st_r.slotAddr};
				default:
					st_nxt.rdata = 32'h0;
			endcase
		end
		if (avs_write && st_r.ack && avs_address == `REG_SETPOINT &&
			|avs_byteenable[1:0])
		begin
			st_nxt.swOverride = 1'b1; // RL9
			if (avs_byteenable[0])
				st_nxt.swSetpoint[7:0] = avs_writedata[7:0];
			if (avs_byteenable[1])
				st_nxt.swSetpoint[15:8] = avs_writedata[15:8];
		end
		st_nxt.setpoint = st_r.swOverride ? st_r.swSetpoint :
			trimSetpoint; // RL9
	end

	// ============================================================
	// State register; reset is the controller restart.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			st_r <= rectifier_pkg::CTL_RESET; // RL10
		else
			st_r <= st_nxt;
	end

	// Outputs straight from the state register.
	assign mainOutputEnable = st_r.outEn;
	assign rampActive = st_r.state == rectifier_pkg::S_RAMP;
	assign powerGood = st_r.powerGood;
	assign mainsIndicator = st_r.mainsInd;
	assign writeProtect = st_r.writeProt;
	assign lineRating = st_r.lineRating;
	assign fault_n = st_r.fault_n;
	assign muxReset = st_r.muxRst;
	assign setpointCode = st_r.setpoint;
	assign slotBitHi = st_r.slotAddr[1];
	assign slotBitLo = st_r.slotAddr[0];
	assign rackBit = st_r.rackBit;
	assign avs_readdata = st_r.rdata;

	// ============================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence s_delayDone;
		st_r.state == rectifier_pkg::S_DELAY && runReq && acOk &&
			st_r.cnt == `CFG_CNT_W'(START_CYCLES - 1);
	endsequence
	sequence s_holdExpired;
		st_r.state == rectifier_pkg::S_HOLD && runReq && !acOk &&
			st_r.cnt == `CFG_CNT_W'(WARN_CYCLES - 1);
	endsequence

	property p_offOnRelease;
		!runReq |=> !mainOutputEnable && !powerGood;
	endproperty
	a_offOnRelease: assert property (p_offOnRelease) // RL1
		else $error("Output stayed on after enable release.");

	property p_seatNeeded;
		pin[`PIN_SEAT_N] |=> !mainOutputEnable;
	endproperty
	a_seatNeeded: assert property (p_seatNeeded) // RL2
		else $error("Output on without seat sense.");

	property p_rampAfterDelay;
		s_delayDone |=> rampActive && mainOutputEnable;
	endproperty
	a_rampAfterDelay: assert property (p_rampAfterDelay) // RL4
		else $error("Ramp did not start after start delay.");

	property p_rampOnlyFromDelay;
		$rose(rampActive) |->
			$past(st_r.cnt) == `CFG_CNT_W'(START_CYCLES - 1);
	endproperty
	a_rampOnlyFromDelay: assert property (p_rampOnlyFromDelay) // RL4
		else $error("Ramp started before the start delay ran out.");

	property p_warnLead;
		s_holdExpired |=> !mainOutputEnable && !powerGood;
	endproperty
	a_warnLead: assert property (p_warnLead) // RL6
		else $error("Output not released after warning time.");

	property p_goodNeedsAc;
		!acOk |=> !powerGood;
	endproperty
	a_goodNeedsAc: assert property (p_goodNeedsAc) // RL6
		else $error("Power good high without AC.");

	property p_indicatorSteady;
		acOk |=> mainsIndicator;
	endproperty
	a_indicatorSteady: assert property (p_indicatorSteady) // RL7
		else $error("Indicator not steady with good AC.");

	property p_overrideHolds;
		st_r.swOverride |=> st_r.swOverride &&
			setpointCode == $past(st_r.swSetpoint);
	endproperty
	a_overrideHolds: assert property (p_overrideHolds) // RL9
		else $error("Software setpoint not kept.");

	property p_writeProtect;
		pin[`PIN_PRESENT] |=> writeProtect;
	endproperty
	a_writeProtect: assert property (p_writeProtect) // RL11
		else $error("Write protect not raised.");

	property p_slotDecode;
		slotCode < `CFG_SLOT_TH2 |=> slotBitHi && slotBitLo;
	endproperty
	a_slotDecode: assert property (p_slotDecode) // RL13
		else $error("Lowest slot range not decoded to 11.");

	property p_faultLow;
		pin[`PIN_OT_WARN] || pin[`PIN_FAN_FAIL] |=> !fault_n;
	endproperty
	a_faultLow: assert property (p_faultLow) // RL16
		else $error("Fault flag not low on fault.");

endmodule

// *** verification/controller_model.sv ***
// Purpose: System controller and backplane model facing the rectifier pins.
// Assumes: One clock; the output regulates a fixed time after enable.
// Notes: The reset pin idles high, as its pull-up would hold it.
// ============================================================
// Controller and power stage model
module controller_model #(
	parameter int REG_DELAY = 3,
	parameter int PULSE_LEN = 30
)
(
	input wire logic clk_sys,
	input wire logic mainOutputEnable,
	input wire logic muxPulseReq,
	output logic outputInRegulation,
	output logic muxResetPin_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int onCnt = 0;
	int pulseCnt = 0;
	logic reqPrev = 1'b0;

	// The output is in regulation only after enable has held a while.
	always_ff @(posedge clk_sys)
	begin
		if (!mainOutputEnable)
			onCnt <= 0;
		else if (onCnt != REG_DELAY)
			onCnt <= onCnt + 1;
	end
	assign outputInRegulation = (onCnt == REG_DELAY);

	// One momentary low pulse per request, long enough to pass debounce.
	always_ff @(posedge clk_sys)
	begin
		reqPrev <= muxPulseReq;
		if (muxPulseReq && !reqPrev)
			pulseCnt <= PULSE_LEN;
		else if (pulseCnt != 0)
			pulseCnt <= pulseCnt - 1;
	end
	assign muxResetPin_n = (pulseCnt == 0);
endmodule

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the rectifier control and status pins.
// Assumes: Shortened sequencing counts; pins settle within 25 cycles.
// Notes: Outputs are sampled at the falling edge to avoid edge races.
`include "rectifier_cfg.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] SHELF_TH [7] = `CFG_SHELF_TH;
	localparam logic [11:0] TRIMS [4] = '{12'hFFF, 12'hE8C, 12'hE8B, 12'h000};
	localparam logic [11:0] SLOTS [5] = '{12'hAAC, 12'hAAB, 12'h7AE,
		12'h499, 12'h498};
	localparam logic [1:0] SLOT_EXP [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
	logic clk_sys, arst_n, remoteOn_n, hotplugSeatSense_n, protocolSel;
	logic presentAbove1V, muxResetPin_n, acInRegulation, biasAvailable;
	logic highLine, outputInRegulation, muxReq, wrqLate, b, rs485;
	logic [4:0] faultVec;
	logic [11:0] trimCode, slotCode, shelfCode;
	logic [3:0] avs_address, be;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, rdLate, d;
	logic mainOutputEnable, rampActive, powerGood, mainsIndicator;
	logic writeProtect, lineRating, fault_n, muxReset;
	logic slotBitHi, slotBitLo, rackBit;
	logic [15:0] setpointCode;
	int n_mismatch = 0;
	int tests_run = 0;
	int k, n;

	rectifier_ctl #(.START_CYCLES(20), .RAMP_CYCLES(30), .WARN_CYCLES(10),
		.BLINK_CYCLES(8)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.remoteOn_n(remoteOn_n), .hotplugSeatSense_n(hotplugSeatSense_n),
		.protocolSel(protocolSel), .rs485Mode(rs485),
		.presentAbove1V(presentAbove1V), .muxResetPin_n(muxResetPin_n),
		.acInRegulation(acInRegulation), .biasAvailable(biasAvailable),
		.highLine(highLine), .outputInRegulation(outputInRegulation),
		.fanFail(faultVec[0]), .overTempWarn(faultVec[1]),
		.overTempShutdown(faultVec[2]), .overVoltShutdown(faultVec[3]),
		.internalFault(faultVec[4]), .trimCode(trimCode),
		.slotCode(slotCode), .shelfCode(shelfCode),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(be), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.mainOutputEnable(mainOutputEnable), .rampActive(rampActive),
		.powerGood(powerGood), .mainsIndicator(mainsIndicator),
		.writeProtect(writeProtect), .lineRating(lineRating),
		.fault_n(fault_n), .muxReset(muxReset),
		.setpointCode(setpointCode), .slotBitHi(slotBitHi),
		.slotBitLo(slotBitLo), .rackBit(rackBit));

	controller_model partner (.clk_sys(clk_sys),
		.mainOutputEnable(mainOutputEnable), .muxPulseReq(muxReq),
		.outputInRegulation(outputInRegulation),
		.muxResetPin_n(muxResetPin_n));

	// ============================================================
	// Clock and bus sampling
	// A 4 ns period gives 250 MHz.
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// Late-cycle values are what the master sees at the next rising edge.
	always @(negedge clk_sys)
	begin
		wrqLate = avs_waitrequest;
		rdLate = avs_readdata;
	end

	// ============================================================
	// Tasks
	// Compare one result and count it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Wait n cycles, ending at a falling edge where outputs are settled.
	task automatic settle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// One Avalon transfer; the request holds until waitrequest is low.
	// The slave always inserts exactly one wait cycle.
	task automatic busXfer(input logic wr, input logic [3:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int c;
		c = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge clk_sys);
			c++;
		end
		while (wrqLate !== 1'b0);
		rd = rdLate;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk(c, 2);
	endtask

	// Trim code to setpoint, worked out independently of the design.
	function automatic logic [15:0] trimExp(input logic [11:0] c);
		logic [31:0] p;
		p = 32'(c) * 32'h578;
		return (c >= 12'hE8C) ? 16'h15E0 : 16'h1130 + p[27:12];
	endfunction

	// Print the verdict and end the run.
	task automatic stop_test();
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ============================================================
	// Tests
	// Sequencing first, then analog decodes, bus, status and faults.
	initial
	begin
		{arst_n, protocolSel, presentAbove1V, muxReq, avs_read} = '0;
		{avs_write, avs_address, avs_writedata, faultVec, rs485} = '0;
		be = 4'hF;
		{remoteOn_n, hotplugSeatSense_n, acInRegulation} = 3'h7;
		{biasAvailable, highLine} = 2'h3;
		{trimCode, slotCode, shelfCode} = {3{12'hFFF}};
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		settle(25);
		chk(fault_n, 1'b1);
		chk(setpointCode, 16'h15E0);
		chk(mainOutputEnable, 1'b0);
		for (int p = 0; p < 2; p++)
		begin
			@(posedge clk_sys);
			protocolSel <= p[0];
			rs485 <= p[0];
			remoteOn_n <= 1'b0;
			hotplugSeatSense_n <= 1'b0;
			for (k = 0; mainOutputEnable !== 1'b1 && k < 200; k++)
				@(negedge clk_sys);
			chk(k >= 38 && k <= 48, 1'b1);
			for (n = 0; rampActive === 1'b1 && n < 200; n++)
				@(negedge clk_sys);
			// In RS485 mode the ramp ends once regulation is debounced.
			chk(n >= (p ? 20 : 28) && n <= (p ? 24 : 32), 1'b1);
			for (k = 0; powerGood !== 1'b1 && k < 40; k++)
				@(negedge clk_sys);
			chk(powerGood, 1'b1);
			@(posedge clk_sys);
			if (p == 0)
				remoteOn_n <= 1'b1;
			else
				hotplugSeatSense_n <= 1'b1;
			settle(25);
			chk(mainOutputEnable, 1'b0);
		end
		@(posedge clk_sys);
		hotplugSeatSense_n <= 1'b0;
		for (k = 0; powerGood !== 1'b1 && k < 150; k++)
			@(negedge clk_sys);
		@(posedge clk_sys);
		acInRegulation <= 1'b0;
		for (k = 0; powerGood === 1'b1 && k < 40; k++)
			@(negedge clk_sys);
		chk(mainOutputEnable, 1'b1);
		for (n = 0; mainOutputEnable === 1'b1 && n < 40; n++)
			@(negedge clk_sys);
		chk(n >= 8 && n <= 12, 1'b1);
		k = 0;
		repeat (40)
		begin
			b = mainsIndicator;
			@(negedge clk_sys);
			k += (mainsIndicator !== b);
		end
		chk(k >= 2, 1'b1);
		@(posedge clk_sys);
		biasAvailable <= 1'b0;
		settle(25);
		chk(mainsIndicator, 1'b0);
		@(posedge clk_sys);
		{biasAvailable, acInRegulation, remoteOn_n} <= 3'h7;
		settle(25);
		chk(mainsIndicator, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_sys);
			trimCode <= TRIMS[i];
			settle(25);
			chk(setpointCode, trimExp(TRIMS[i]));
		end
		busXfer(1'b1, 4'h4, 32'h0000_1234, d);
		settle(3);
		chk(setpointCode, 16'h1234);
		@(posedge clk_sys);
		trimCode <= 12'h800;
		settle(25);
		chk(setpointCode, 16'h1234);
		@(posedge clk_sys);
		be <= 4'h1;
		busXfer(1'b1, 4'h4, 32'h0000_55AA, d);
		be <= 4'hF;
		settle(3);
		chk(setpointCode, 16'h12AA);
		busXfer(1'b0, 4'h4, 32'h0, d);
		chk(d, 32'h0000_12AA);
		busXfer(1'b0, 4'h0, 32'h0, d);
		chk(d[6], 1'b1);
		busXfer(1'b0, 4'hC, 32'h0, d);
		chk(d, 32'h0);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		// No mux reset pulse may follow a released reset.
		k = 0;
		repeat (25)
		begin
			@(negedge clk_sys);
			k += (muxReset === 1'b1);
		end
		chk(k, 0);
		chk(setpointCode, trimExp(12'h800));
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk_sys);
			slotCode <= SLOTS[i];
			settle(25);
			chk({slotBitHi, slotBitLo}, SLOT_EXP[i]);
		end
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_sys);
			shelfCode <= (i < 7) ? SHELF_TH[i] : 12'h000;
			settle(25);
			chk(rackBit, i[0]);
		end
		busXfer(1'b0, 4'h8, 32'h0, d);
		chk(d[2:0], 3'h7);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk_sys);
			highLine <= i[0];
			settle(25);
			chk(lineRating, i[0]);
		end
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk_sys);
			faultVec <= 5'h01 << i;
			settle(25);
			chk(fault_n, 1'b0);
			@(posedge clk_sys);
			faultVec <= 5'h00;
			settle(25);
			chk(fault_n, 1'b1);
		end
		@(posedge clk_sys);
		faultVec <= 5'h01;
		repeat (3) @(posedge clk_sys);
		faultVec <= 5'h00;
		k = 0;
		repeat (30)
		begin
			@(negedge clk_sys);
			k += (fault_n !== 1'b1);
		end
		chk(k, 0);
		for (int i = 1; i >= 0; i--)
		begin
			@(posedge clk_sys);
			presentAbove1V <= i[0];
			settle(25);
			chk(writeProtect, i[0]);
		end
		@(posedge clk_sys);
		muxReq <= 1'b1;
		k = 0;
		repeat (60)
		begin
			@(negedge clk_sys);
			k += (muxReset === 1'b1);
		end
		chk(k, 1);
		stop_test();
	end

	// A hang counts as a mismatch and ends the run in the same place.
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		stop_test();
	end
endmodule
